/* core/asq_pkg.sv */
// Shared constants, types and the result formatting function of the converter sequencer.
package asq_pkg;

    // System clock and converter clock rates; the converter clock is an enable pulse from a divider.
    localparam int CLK_HZ = 50_000_000;
    localparam int ADC_CLK_HZ = 2_000_000;
    localparam int ADC_DIV = CLK_HZ / ADC_CLK_HZ;
    localparam int DIV_W = 5;
    localparam logic [DIV_W-1:0] ADC_DIV_LAST = DIV_W'(ADC_DIV - 1);
    // Divider value loaded by a start strobe, so that the first phase lasts whole converter cycles.
    localparam logic [DIV_W-1:0] DIV_RESTART = 5'h01;

    // Phase lengths in converter clock cycles.
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] INIT_TICKS = 5'h02;
    localparam logic [CNT_W-1:0] XFER_TICKS = 5'h02;
    localparam logic [CNT_W-1:0] FINAL_BASE_TICKS = 5'h02;
    localparam logic [CNT_W-1:0] RES8_TICKS = 5'h0A;
    localparam logic [CNT_W-1:0] RES10_TICKS = 5'h0C;

    // Approximation register layout.
    localparam int RES_W = 10;
    localparam int POS_W = 4;
    localparam logic [POS_W-1:0] MSB8_POS = 4'h7;
    localparam logic [POS_W-1:0] MSB10_POS = 4'h9;
    localparam logic [POS_W-1:0] LSB_POS = 4'h0;

    // Sequence layout: eight result slots, sequences of four or eight conversions.
    localparam int SLOTS = 8;
    localparam int IDX_W = 3;
    localparam logic [IDX_W-1:0] SEQ_LAST_SHORT = 3'h3;
    localparam logic [IDX_W-1:0] SEQ_LAST_LONG = 3'h7;

    // Mode number bit positions: scan, multi-channel, eight-conversion.
    localparam int MODE_EIGHT_BIT = 0;
    localparam int MODE_MULTI_BIT = 1;
    localparam int MODE_SCAN_BIT = 2;

    // Result read port: address is {format, slot}.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [1:0] FMT_SIGNED_LEFT = 2'h0;
    localparam logic [1:0] FMT_UNSIGNED_RIGHT = 2'h1;
    localparam logic [1:0] FMT_UNSIGNED_LEFT = 2'h2;

    // Conversion phases, Gray coded from idle through resolution; the step from resolution back to initial sample changes all three bits.
    typedef enum logic [2:0]
    {
        PH_IDLE = 3'b000,
        PH_INIT = 3'b001,
        PH_XFER = 3'b011,
        PH_FINAL = 3'b010,
        PH_RESOLVE = 3'b110
    } asq_phase_type;

    // Fields of converter_control_zero and converter_control_one.
    typedef struct packed {
        logic scan;
        logic multiChannelSelect;
        logic eightConversionSelect;
        logic bits10;
        logic [1:0] finalSampleTimeField;
        logic [3:0] channelSelectBits;
    } asq_config_type;

    // Analog switch controls.
    typedef struct packed {
        logic sampleToAmp;
        logic ampToDac;
        logic muxToDac;
    } asq_switch_type;

    // Returns a stored result in one of the three read formats.
    function automatic logic [DATA_W-1:0] asq_format(input logic [1:0] fmt, input logic [RES_W-1:0] val,
                                                    input logic bits10);
        logic [DATA_W-1:0] left;
        logic [DATA_W-1:0] right;
        left = bits10 ? {val, 6'h00} : {val[7:0], 8'h00};
        right = bits10 ? {6'h00, val} : {8'h00, val[7:0]};
        case (fmt)
            FMT_SIGNED_LEFT: asq_format = {~left[DATA_W-1], left[DATA_W-2:0]};
            FMT_UNSIGNED_RIGHT: asq_format = right;
            FMT_UNSIGNED_LEFT: asq_format = left;
            default: asq_format = 16'h0000;
        endcase
    endfunction : asq_format

endpackage : asq_pkg

/* core/asq_approx.sv */
// Successive approximation register with comparator synchroniser.
`timescale 1ns/1ps
module asq_approx
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Converter clock enable and resolution control.
    input wire logic tick,
    input wire logic start,
    input wire logic bits10,
    // Comparator from the analog array, high when the input is at or above the trial level.
    input wire logic compareIn,
    // Trial code driving the capacitor-resistor array, and the resolved value.
    output logic [asq_pkg::RES_W-1:0] code
);
    import asq_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic active;
        logic [POS_W-1:0] pos;
        logic [RES_W-1:0] code;
    } asq_approx_state_type;

    asq_approx_state_type s_r;
    asq_approx_state_type s_nxt;

    // Next state: synchronise the comparator, then resolve one bit per converter cycle.
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sync1 = compareIn;
        s_nxt.sync2 = s_r.sync1;
        if (tick)
        begin
            if (start)
            begin
                s_nxt.code = '0;
                s_nxt.pos = bits10 ? MSB10_POS : MSB8_POS;
                s_nxt.code[s_nxt.pos] = 1'b1;
                s_nxt.active = 1'b1;
            end
            else if (s_r.active)
            begin
                if (!s_r.sync2)
                begin
                    s_nxt.code[s_r.pos] = 1'b0;
                end
                if (s_r.pos == LSB_POS)
                begin
                    s_nxt.active = 1'b0;
                end
                else
                begin
                    s_nxt.pos = s_r.pos - 1'b1;
                    s_nxt.code[s_nxt.pos] = 1'b1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign code = s_r.code;

endmodule : asq_approx

/* core/asq_sequencer.sv */
// Conversion sequencer, phase timing and result registers of the converter.
//
// Behaviour
// - With multi-channel set, four-conversion groups ignore the low two select bits and use the top two bits to pick inputs 0-3, 4-7, reserved or the reference set, while eight-conversion groups use the top bit to pick inputs 0-7 or reserved plus references.
// - Every conversion runs initial sample, transfer, final sample and resolution in that order.
// - The switch controls follow the phase: sample capacitor to amplifier, amplifier to array, then multiplexer straight to array.
// - Initial sample and transfer each last exactly two converter cycles.
// - Final sample lasts 2, 4, 8 or 16 converter cycles as set by the final sample time field.
// - Resolution lasts ten converter cycles for 8-bit and twelve for 10-bit conversions.
// - Resolution starts with only the top bit set, then each comparison keeps or clears the trial bit and tries the next lower one.
// - A finished conversion copies the approximation value into the result slot of that conversion.
// - Each result reads at three addresses whose format differs, and reading never changes it.
// - Results are read over the bus interface unit read port.
// - Unsigned right-justified reads give bits 9-0 or 7-0 with all upper bits zero.
// - Signed left-justified reads give offset two's complement in bits 15-6 or 15-8 with low bits zero.
// - Unsigned left-justified reads give bits 15-6 or 15-8 with low bits zero.
// - The mode number is scan, multi-channel and eight-conversion read as a three-bit value.
// - Each result write sets its conversion complete flag, and the end of the first sequence sets the sequence complete flag.
// - Continuous-scan modes restart the sequence and overwrite the same result slots.
`timescale 1ns/1ps
module asq_sequencer
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control register fields and the start strobe issued on a control register one write.
    input wire asq_pkg::asq_config_type cfg,
    input wire logic startConv,
    // Converter status.
    output logic [asq_pkg::SLOTS-1:0] conversionCompleteFlag,
    output logic sequenceCompleteFlag,
    output logic busy,
    // Analog front end controls.
    output logic [3:0] muxChannel,
    output asq_pkg::asq_switch_type switches,
    output logic [asq_pkg::RES_W-1:0] dacCode,
    input wire logic compareIn,
    // Result read port of the bus interface unit.
    input wire logic rdEn,
    input wire logic [asq_pkg::ADDR_W-1:0] rdAddr,
    output logic [asq_pkg::DATA_W-1:0] rdData,
    output logic rdValid
);
    import asq_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic tick;
        asq_phase_type phase;
        logic [CNT_W-1:0] cnt;
        asq_config_type cfg;
        logic [IDX_W-1:0] idx;
        logic firstSeq;
        logic [3:0] chan;
        asq_switch_type sw;
        logic [SLOTS-1:0] ccf;
        logic sequence_complete_flag;
        logic [SLOTS-1:0][RES_W-1:0] result;
        logic [SLOTS-1:0] resBits10;
        logic [DATA_W-1:0] rdData;
        logic rdValid;
    } asq_seq_state_type;

    asq_seq_state_type s_r;
    asq_seq_state_type s_nxt;
    logic [RES_W-1:0] sarCode;
    logic sarStart;
    logic [SLOTS-1:0] ccfSet;
    logic scfSet;
    logic [IDX_W-1:0] rdSlot;
    logic [1:0] rdFmt;

    // Mode number from the configuration bits.
    function automatic logic [2:0] mode_of(input asq_config_type c);
        mode_of = {c.scan, c.multiChannelSelect, c.eightConversionSelect};
    endfunction : mode_of

    // Index of the last conversion of a sequence.
    function automatic logic [IDX_W-1:0] seq_last(input asq_config_type c);
        logic [2:0] m;
        m = mode_of(c);
        seq_last = m[MODE_EIGHT_BIT] ? SEQ_LAST_LONG : SEQ_LAST_SHORT;
    endfunction : seq_last

    // Multiplexer channel for a given conversion of the sequence.
    function automatic logic [3:0] chan_for(input asq_config_type c, input logic [IDX_W-1:0] i);
        logic [2:0] m;
        m = mode_of(c);
        if (!m[MODE_MULTI_BIT])
        begin
            chan_for = c.channelSelectBits;
        end
        else if (m[MODE_EIGHT_BIT])
        begin
            chan_for = {c.channelSelectBits[3], i};
        end
        else
        begin
            chan_for = {c.channelSelectBits[3:2], i[1:0]};
        end
    endfunction : chan_for

    // Length of the final sample phase.
    function automatic logic [CNT_W-1:0] final_len(input logic [1:0] sts);
        final_len = CNT_W'(FINAL_BASE_TICKS << sts);
    endfunction : final_len

    // Length of the resolution phase.
    function automatic logic [CNT_W-1:0] res_len(input logic bits10);
        res_len = bits10 ? RES10_TICKS : RES8_TICKS;
    endfunction : res_len

    // Switch settings held during each phase.
    function automatic asq_switch_type switch_for(input asq_phase_type p);
        switch_for = '0;
        case (p)
            PH_INIT: switch_for.sampleToAmp = 1'b1;
            PH_XFER: switch_for.ampToDac = 1'b1;
            PH_FINAL: switch_for.muxToDac = 1'b1;
            default: switch_for = '0;
        endcase
    endfunction : switch_for

    // The approximation register resolves one bit per converter cycle.
    asq_approx u_approx
    (
        .clk(clk),
        .rst(rst),
        .tick(s_r.tick),
        .start(sarStart),
        .bits10(s_r.cfg.bits10),
        .compareIn(compareIn),
        .code(sarCode)
    );

    // First converter cycle of resolution starts the search.
    assign sarStart = s_r.tick && (s_r.phase == PH_RESOLVE) && (s_r.cnt == res_len(s_r.cfg.bits10));
    assign rdSlot = rdAddr[IDX_W-1:0];
    assign rdFmt = rdAddr[ADDR_W-1:IDX_W];

    // Next state: divider, phase sequencing, result storage, flags and read port.
    always_comb
    begin
        s_nxt = s_r;
        ccfSet = '0;
        scfSet = 1'b0;
        s_nxt.tick = 1'b0;
        if (s_r.div == ADC_DIV_LAST)
        begin
            s_nxt.div = '0;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.div = s_r.div + 1'b1;
        end
        if (s_r.tick && (s_r.phase != PH_IDLE))
        begin
            if (s_r.cnt != CNT_ONE)
            begin
                s_nxt.cnt = s_r.cnt - CNT_ONE;
            end
            else
            begin
                case (s_r.phase)
                    PH_INIT:
                    begin
                        s_nxt.phase = PH_XFER;
                        s_nxt.cnt = XFER_TICKS;
                    end
                    PH_XFER:
                    begin
                        s_nxt.phase = PH_FINAL;
                        s_nxt.cnt = final_len(s_r.cfg.finalSampleTimeField);
                    end
                    PH_FINAL:
                    begin
                        s_nxt.phase = PH_RESOLVE;
                        s_nxt.cnt = res_len(s_r.cfg.bits10);
                    end
                    PH_RESOLVE:
                    begin
                        s_nxt.result[s_r.idx] = sarCode;
                        s_nxt.resBits10[s_r.idx] = s_r.cfg.bits10;
                        ccfSet[s_r.idx] = 1'b1;
                        s_nxt.phase = PH_INIT;
                        s_nxt.cnt = INIT_TICKS;
                        if (s_r.idx == seq_last(s_r.cfg))
                        begin
                            scfSet = s_r.firstSeq;
                            s_nxt.firstSeq = 1'b0;
                            s_nxt.idx = '0;
                            if (!s_r.cfg.scan)
                            begin
                                s_nxt.phase = PH_IDLE;
                            end
                        end
                        else
                        begin
                            s_nxt.idx = s_r.idx + 1'b1;
                        end
                        s_nxt.chan = chan_for(s_r.cfg, s_nxt.idx);
                    end
                    default:
                    begin
                        s_nxt.phase = PH_IDLE;
                    end
                endcase
            end
        end
        // A start strobe aborts any sequence, realigns the converter clock and begins a new one with fresh flags.
        // Without the realignment the first initial sample phase would be cut short by a partial converter cycle.
        if (startConv)
        begin
            s_nxt.div = DIV_RESTART;
            s_nxt.tick = 1'b0;
            s_nxt.cfg = cfg;
            s_nxt.idx = '0;
            s_nxt.firstSeq = 1'b1;
            s_nxt.phase = PH_INIT;
            s_nxt.cnt = INIT_TICKS;
            s_nxt.chan = chan_for(cfg, '0);
        end
        // Set wins over the clear made by a start strobe.
        s_nxt.ccf = (startConv ? '0 : s_r.ccf) | ccfSet;
        s_nxt.sequence_complete_flag = (startConv ? 1'b0 : s_r.sequence_complete_flag) | scfSet;
        s_nxt.sw = switch_for(s_nxt.phase);
        // Reads leave the stored value untouched and answer one cycle later.
        s_nxt.rdValid = rdEn;
        if (rdEn)
        begin
            s_nxt.rdData = asq_format(rdFmt, s_r.result[rdSlot], s_r.resBits10[rdSlot]);
        end
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs come from the state register, except dacCode from the approximation register and busy decoded from the phase.
    assign conversionCompleteFlag = s_r.ccf;
    assign sequenceCompleteFlag = s_r.sequence_complete_flag;
    assign busy = (s_r.phase != PH_IDLE);
    assign muxChannel = s_r.chan;
    assign switches = s_r.sw;
    assign dacCode = sarCode;
    assign rdData = s_r.rdData;
    assign rdValid = s_r.rdValid;

endmodule : asq_sequencer

/* dv/asq_sequencer_chk.sv */
// Port assertions of the converter sequencer.
`timescale 1ns/1ps
module asq_sequencer_chk
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control and status.
    input wire asq_pkg::asq_config_type cfg,
    input wire logic startConv,
    input wire logic [asq_pkg::SLOTS-1:0] conversionCompleteFlag,
    input wire logic sequenceCompleteFlag,
    input wire logic busy,
    // Analog front end.
    input wire logic [3:0] muxChannel,
    input wire asq_pkg::asq_switch_type switches,
    input wire logic [asq_pkg::RES_W-1:0] dacCode,
    input wire logic compareIn,
    // Read port.
    input wire logic rdEn,
    input wire logic [asq_pkg::ADDR_W-1:0] rdAddr,
    input wire logic [asq_pkg::DATA_W-1:0] rdData,
    input wire logic rdValid
);
    import asq_pkg::*;
    logic [3:0] firstCh;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // First channel of a sequence as the select bits and group size ask.
    assign firstCh = !cfg.multiChannelSelect ? cfg.channelSelectBits : cfg.eightConversionSelect ?
        {cfg.channelSelectBits[3], 3'h0} : {cfg.channelSelectBits[3:2], 2'h0};
    chk_read_answer: assert property (rdEn |=> rdValid) else $error("read not answered");
    chk_read_quiet: assert property (!rdEn |=> !rdValid) else $error("read valid without strobe");
    chk_fmt_unmapped: assert property (rdEn && rdAddr[4:3] == 2'h3 |=> rdData == 16'h0000)
        else $error("unmapped format not zero");
    chk_right_upper: assert property (rdEn && rdAddr[4:3] == FMT_UNSIGNED_RIGHT |=> rdData[15:10] == 6'h00)
        else $error("right format upper bits set");
    chk_left_lower: assert property (rdEn && rdAddr[4:3] != FMT_UNSIGNED_RIGHT |=> rdData[5:0] == 6'h00)
        else $error("left format lower bits set");
    chk_start_sample: assert property (startConv |=> busy && switches == 3'b100)
        else $error("sequence did not open with initial sample");
    chk_switch_onehot: assert property (busy |-> $onehot0(switches)) else $error("two switches closed");
    chk_idle_open: assert property (!busy |-> switches == 3'b000) else $error("switch closed while idle");
    chk_flags_hold: assert property (!startConv |=> (conversionCompleteFlag & $past(conversionCompleteFlag)) ==
        $past(conversionCompleteFlag)) else $error("complete flag cleared without start");
    chk_seq_flags: assert property ($rose(sequenceCompleteFlag) |-> conversionCompleteFlag[3:0] == 4'hF)
        else $error("sequence flag before results");
    chk_first_channel: assert property (startConv |=> muxChannel == $past(firstCh))
        else $error("wrong first channel");
    chk_init_length: assert property (disable iff (rst || startConv) $rose(switches.sampleToAmp) |->
        ##49 switches.sampleToAmp ##1 switches.ampToDac) else $error("initial sample not two converter cycles");
    chk_xfer_length: assert property (disable iff (rst || startConv) $rose(switches.ampToDac) |->
        ##49 switches.ampToDac ##1 switches.muxToDac) else $error("transfer not two converter cycles");
    chk_trial_msb: assert property (disable iff (rst || startConv) $fell(switches.muxToDac) && busy &&
        switches == 3'b000 |-> ##[1:27] dacCode == (cfg.bits10 ? 10'h200 : 10'h080))
        else $error("resolution did not start at top bit");
endmodule : asq_sequencer_chk

bind asq_sequencer asq_sequencer_chk chk_u (.clk(clk), .rst(rst), .cfg(cfg), .startConv(startConv),
    .conversionCompleteFlag(conversionCompleteFlag), .sequenceCompleteFlag(sequenceCompleteFlag), .busy(busy),
    .muxChannel(muxChannel), .switches(switches), .dacCode(dacCode), .compareIn(compareIn), .rdEn(rdEn),
    .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid));

/* dv/asq_afe_model.sv */
// Comparator model of the analog input array.
`timescale 1ns/1ps
module asq_afe_model
(
    // Clock.
    input wire logic clk,
    // Selected input, resolution and trial code.
    input wire logic [3:0] muxChannel,
    input wire logic bits10,
    input wire logic [asq_pkg::RES_W-1:0] dacCode,
    // High while the input is at or above the trial level.
    output logic compareIn
);
    import asq_pkg::*;
    logic [RES_W-1:0] level;
    // Every input carries its own fixed level so that results tell channels apart.
    assign level = RES_W'(muxChannel * 61 + 7);
    // The comparator output moves only after an edge, like a settling analog stage.
    always_ff @(posedge clk)
    begin
        compareIn <= bits10 ? (dacCode <= level) : (dacCode[7:0] <= level[9:2]);
    end
endmodule : asq_afe_model

/* dv/tb.sv */
// Self-checking testbench of the converter sequencer.
`timescale 1ns/1ps
module tb;
    import asq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    asq_config_type cfg = '0;
    logic startConv = 1'b0;
    logic rdEn = 1'b0;
    logic [ADDR_W-1:0] rdAddr = '0;
    logic [SLOTS-1:0] conversionCompleteFlag;
    logic sequenceCompleteFlag;
    logic busy;
    logic compareIn;
    logic rdValid;
    logic [3:0] muxChannel;
    asq_switch_type switches;
    logic [RES_W-1:0] dacCode;
    logic [DATA_W-1:0] rdData;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int finalCnt = 0;
    int resCnt = 0;
    logic [3:0] sels [8] = '{4'h5, 4'hA, 4'hC, 4'h9, 4'h2, 4'hF, 4'h4, 4'h1};

    always #10 clk = ~clk;

    asq_sequencer dut_u (.clk(clk), .rst(rst), .cfg(cfg), .startConv(startConv),
        .conversionCompleteFlag(conversionCompleteFlag), .sequenceCompleteFlag(sequenceCompleteFlag), .busy(busy),
        .muxChannel(muxChannel), .switches(switches), .dacCode(dacCode), .compareIn(compareIn), .rdEn(rdEn),
        .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid));

    asq_afe_model afe_u (.clk(clk), .muxChannel(muxChannel), .bits10(cfg.bits10), .dacCode(dacCode),
        .compareIn(compareIn));

    // Counts run time, final sample cycles and resolution cycles; a hang ends the run.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (switches.muxToDac)
            finalCnt <= finalCnt + 1;
        if (busy && switches == 3'b000)
            resCnt <= resCnt + 1;
        if (cycles == 60000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One read cycle: strobe for a cycle, answer one cycle later.
    task automatic read(input logic [1:0] fmt, input logic [2:0] slot, input logic [15:0] exp);
        @(posedge clk);
        rdEn <= 1'b1;
        rdAddr <= {fmt, slot};
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        check("rdValid", 16'(rdValid), 16'h0001);
        check("rdData", rdData, exp);
    endtask : read

    // Runs one sequence in mode m and checks timing totals, flags and every result format.
    task automatic run_mode(input logic [2:0] m);
        int n;
        int fb;
        int rb;
        int d;
        logic b10;
        logic [3:0] ch;
        logic [9:0] v;
        logic [15:0] left;
        n = m[0] ? 8 : 4;
        b10 = m[1] ^ m[2];
        @(posedge clk);
        cfg <= {m, b10, m[1:0], sels[m]};
        startConv <= 1'b1;
        @(posedge clk);
        startConv <= 1'b0;
        #1;
        fb = finalCnt;
        rb = resCnt;
        check("cleared", 16'(conversionCompleteFlag), 16'h0000);
        while (sequenceCompleteFlag !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
        check("flags", 16'(conversionCompleteFlag), n == 8 ? 16'h00FF : 16'h000F);
        check("busy", 16'(busy), 16'(m[2]));
        d = finalCnt - fb - n * 25 * (2 << m[1:0]);
        check("final", 16'(d >= -n && d <= n), 16'h0001);
        d = resCnt - rb - n * 25 * (b10 ? 12 : 10);
        check("resolve", 16'(d >= -n && d <= n), 16'h0001);
        for (int i = 0; i < n; i++)
        begin
            ch = !m[1] ? sels[m] : m[0] ? {sels[m][3], 3'(i)} : {sels[m][3:2], 2'(i)};
            v = 10'(ch * 61 + 7);
            if (!b10)
                v = {2'h0, v[9:2]};
            left = b10 ? {v, 6'h00} : {v[7:0], 8'h00};
            read(FMT_UNSIGNED_RIGHT, 3'(i), {6'h00, v});
            read(FMT_UNSIGNED_LEFT, 3'(i), left);
            read(FMT_SIGNED_LEFT, 3'(i), left ^ 16'h8000);
            read(2'h3, 3'(i), 16'h0000);
        end
    endtask : run_mode

    // Reset, cleared results, then every conversion mode in turn.
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("busy", 16'(busy), 16'h0000);
        for (int f = 0; f < 4; f++)
            read(2'(f), 3'h5, (2'(f) == FMT_SIGNED_LEFT) ? 16'h8000 : 16'h0000);
        for (int m = 0; m < 8; m++)
            run_mode(3'(m));
        test_done();
    end
endmodule : tb
